// *** tb_ttrx_status.sv ***
// Self-checking testbench for the trail trace receive status block
`timescale 1ns/1ps
module tb_ttrx_status;
    reg i_ref_clk = 1'b0;
    reg i_rst_n = 1'b0;
    reg [7:0] i_addr = 8'h00;
    reg [15:0] i_wdata = 16'h0000;
    reg i_wr = 1'b0;
    reg i_rd = 1'b0;
    wire [15:0] o_rdata;
    wire [7:0] lb;
    wire lv;
    wire ls;
    wire o_irq;
    integer err_total = 0;
    integer compares = 0;
    integer cyc = 0;
    integer k;
    always #4 i_ref_clk = ~i_ref_clk;
    ttrx_status uut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_line_byte(lb), .i_line_valid(lv), .i_line_ident_start(ls), .o_irq(o_irq));
    ttrx_far_tx far (.i_clk(i_ref_clk), .o_byte(lb), .o_valid(lv), .o_start(ls));
    task tally_and_finish;
        begin
            $display("mismatches %0d comparisons %0d", err_total, compares);
            if (err_total == 0 && compares > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_total = err_total + 1;
            $display("CHECK FAILED %0t timeout", $time);
            tally_and_finish;
        end
    end
    task chk(input [15:0] got, input [15:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Ends just after the taking edge so a read result or irq can be checked at once
    task bus(input w, input [7:0] a, input [15:0] d);
        begin
            @(posedge i_ref_clk);
            i_wr <= w;
            i_rd <= !w;
            i_addr <= a;
            i_wdata <= d;
            @(posedge i_ref_clk);
            i_wr <= 1'b0;
            i_rd <= 1'b0;
            #1;
        end
    endtask
    task rd(input [7:0] a, input [15:0] e);
        begin
            bus(1'b0, a, 16'h0000);
            chk(o_rdata, e);
        end
    endtask
    task tx(input [7:0] b, input [7:0] s, input slow);
        reg [127:0] f;
        integer j;
        begin
            for (j = 0; j < 16; j = j + 1)
                f[j*8 +: 8] = b + s * j[7:0];
            far.send(f, slow);
            repeat (4) @(posedge i_ref_clk);
        end
    endtask
    task t_reset;
        begin
            rd(8'hF2, 16'h0000);
            rd(8'hF8, 16'h0000);
            rd(8'hFC, 16'h0000);
            rd(8'hFE, 16'h0000);
            rd(8'hFA, 16'h0000);
            rd(8'hF6, 16'h0000);
        end
    endtask
    task t_idle;
        begin
            repeat (4) tx(8'h00, 8'h00, 1'b0);
            rd(8'hF4, 16'h0000);
            tx(8'h00, 8'h00, 1'b1);
            rd(8'hF4, 16'h0001);
            rd(8'hF6, 16'h0001);
        end
    endtask
    task t_change;
        begin
            bus(1'b1, 8'hF2, 16'h0000);
            tx(8'hA0, 8'h01, 1'b0);
            rd(8'hF6, 16'h0001);
            rd(8'hF4, 16'h0000);
            tx(8'hA0, 8'h01, 1'b1);
            rd(8'hF6, 16'h000D);
            rd(8'hF4, 16'h0004);
            for (k = 0; k < 17; k = k + 1)
                rd(8'hFC, {8'h00, 8'hA0 + k[3:0]});
            rd(8'hF2, 16'h0001);
        end
    endtask
    task t_exp;
        begin
            bus(1'b1, 8'hF6, 16'h000F);
            rd(8'hF6, 16'h0000);
            for (k = 0; k < 16; k = k + 1)
                bus(1'b1, 8'hFE, {8'hFF, 8'hA0 + k[3:0]});
            for (k = 0; k < 16; k = k + 1)
                rd(8'hFE, {8'h00, 8'hA0 + k[3:0]});
            rd(8'hF4, 16'h0000);
            rd(8'hF6, 16'h0000);
        end
    endtask
    task t_mism;
        begin
            bus(1'b1, 8'hF2, 16'h0000);
            bus(1'b1, 8'hFE, 16'h0055);
            rd(8'hF2, 16'h0100);
            rd(8'hF4, 16'h0004);
            rd(8'hF6, 16'h0004);
            bus(1'b1, 8'hF6, 16'h0004);
            tx(8'hA0, 8'h01, 1'b0);
            rd(8'hF6, 16'h0000);
        end
    endtask
    task t_unst;
        begin
            for (k = 0; k < 7; k = k + 1)
                tx(8'h10 + k[7:0], 8'h01, 1'b0);
            rd(8'hF4, 16'h0004);
            tx(8'h17, 8'h01, 1'b0);
            rd(8'hF4, 16'h0006);
            rd(8'hF6, 16'h0002);
        end
    endtask
    task t_irq;
        begin
            bus(1'b1, 8'hF8, 16'h0002);
            chk(o_irq, 16'h0000);
            bus(1'b1, 8'hF0, 16'h0001);
            chk(o_irq, 16'h0001);
            bus(1'b1, 8'hF8, 16'h000D);
            chk(o_irq, 16'h0000);
            bus(1'b1, 8'hF8, 16'h000F);
            rd(8'hF8, 16'h000F);
            chk(o_irq, 16'h0001);
            bus(1'b1, 8'hF0, 16'h0000);
            chk(o_irq, 16'h0000);
            bus(1'b1, 8'hF0, 16'h0001);
            bus(1'b1, 8'hF6, 16'h0002);
            chk(o_irq, 16'h0000);
        end
    endtask
    initial begin
        repeat (10) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        t_reset;
        t_idle;
        t_change;
        t_exp;
        t_mism;
        t_unst;
        t_irq;
        tally_and_finish;
    end
endmodule // tb_ttrx_status

// *** ttrx_defs.vh ***
// Register offsets, field positions, reset values and counts for the trail trace receive status block
`ifndef TTRX_DEFS_VH
`define TTRX_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TTRX_ADDR_W 8
`define TTRX_OFF_LIVE_STATUS 8'hF4
`define TTRX_OFF_LATCHED 8'hF6
`define TTRX_OFF_IRQ_EN 8'hF8
`define TTRX_OFF_PTRS 8'hF2
`define TTRX_OFF_RX_IDENT 8'hFC
`define TTRX_OFF_EXP_IDENT 8'hFE
`define TTRX_OFF_CTRL 8'hF0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TTRX_BIT_CHANGE 3
`define TTRX_BIT_MISMATCH 2
`define TTRX_BIT_UNSTABLE 1
`define TTRX_BIT_IDLE 0
`define TTRX_BIT_GLOBAL_EN 0
`define TTRX_EXP_PTR_LSB 8

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define TTRX_IRQ_EN_RST 4'h0
`define TTRX_IDLE_COUNT 3'h5
`define TTRX_UNSTABLE_COUNT 4'h8

`endif

// *** ttrx_far_tx.sv ***
// Far-end line transmitter model sending 16-byte trail trace identifiers
`timescale 1ns/1ps
module ttrx_far_tx (
    input wire i_clk,
    output reg [7:0] o_byte,
    output reg o_valid,
    output reg o_start
);
    initial begin
        o_byte = 8'h00;
        o_valid = 1'b0;
        o_start = 1'b0;
    end
    // Slow mode stretches hold and gap, as a lower line rate would
    task send(input [127:0] f, input slow);
        integer j;
        integer h;
        begin
            h = slow ? 6 : 4;
            for (j = 0; j < 16; j = j + 1) begin
                @(posedge i_clk);
                o_byte <= f[j*8 +: 8];
                o_start <= (j == 0);
                o_valid <= 1'b1;
                repeat (h) @(posedge i_clk);
                o_valid <= 1'b0;
                o_start <= 1'b0;
                // Released line must not keep showing the byte
                o_byte <= ~f[j*8 +: 8];
                repeat (h) @(posedge i_clk);
            end
        end
    endtask
endmodule // ttrx_far_tx

// *** ttrx_status.v ***
// Trail trace receive identifier monitor with status, interrupt and identifier access registers
`timescale 1ns/1ps
`include "ttrx_defs.vh"
module ttrx_status #(
    parameter IDENT_BYTES = 16,
    parameter PTR_W = 4
) (
    input wire i_ref_clk,
    input wire i_rst_n,
    input wire [7:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [15:0] o_rdata,
    input wire [7:0] i_line_byte,
    input wire i_line_valid,
    input wire i_line_ident_start,
    output wire o_irq
);

// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------
// One step of a byte pointer; its width equals the store depth, so Fh rolls over to 0h
function [PTR_W-1:0] ptr_step;
    input [PTR_W-1:0] ptr;
    begin
        ptr_step = ptr + {{(PTR_W-1){1'b0}}, 1'b1};
    end
endfunction

function bus_hit;
    input strobe;
    input [7:0] addr;
    input [7:0] offset;
    begin
        bus_hit = strobe & (addr == offset);
    end
endfunction

// ----------------------------------------------------------------
// Reset release and line input synchronisers
// ----------------------------------------------------------------
reg [1:0] rst_sync_ff;
wire rst_n;
reg [7:0] byte_s1_ff;
reg [7:0] byte_s2_ff;
reg valid_s1_ff;
reg valid_s2_ff;
reg start_s1_ff;
reg start_s2_ff;
reg valid_d_ff;
reg valid_d2_ff;
wire byte_take;

// Reset drops at once but leaves on the clock, two flops after the pin
always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
        rst_sync_ff <= 2'h0;
    end else begin
        rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
end
assign rst_n = rst_sync_ff[1];

// Line strobes come from outside this clock, so they are synchronised; only valid is edge-detected, after stage two
always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        byte_s1_ff <= 8'h00;
        byte_s2_ff <= 8'h00;
        valid_s1_ff <= 1'b0;
        valid_s2_ff <= 1'b0;
        start_s1_ff <= 1'b0;
        start_s2_ff <= 1'b0;
        valid_d_ff <= 1'b0;
        valid_d2_ff <= 1'b0;
    end else begin
        byte_s1_ff <= i_line_byte;
        byte_s2_ff <= byte_s1_ff;
        valid_s1_ff <= i_line_valid;
        valid_s2_ff <= valid_s1_ff;
        start_s1_ff <= i_line_ident_start;
        start_s2_ff <= start_s1_ff;
        valid_d_ff <= valid_s2_ff;
        valid_d2_ff <= valid_d_ff;
    end
end
// Take one cycle after the strobe settles, so a byte bit that resolved late has reached stage two too
assign byte_take = valid_d_ff & ~valid_d2_ff;

// ----------------------------------------------------------------
// Identifier stores
// ----------------------------------------------------------------
reg [7:0] rx_ident_ff [0:IDENT_BYTES-1];
reg [7:0] exp_ident_ff [0:IDENT_BYTES-1];
reg [7:0] asm_ff [0:IDENT_BYTES-1];
reg [7:0] last_ff [0:IDENT_BYTES-1];
reg [PTR_W-1:0] asm_ptr_ff;
reg asm_run_ff;
reg [PTR_W-1:0] rx_ident_byte_ptr_ff;
reg [PTR_W-1:0] expected_ident_byte_ptr_ff;
reg ident_done;
reg asm_zero;
reg asm_eq_last;
reg asm_eq_cur;
reg ident_mismatch;
integer i;
integer n;
integer m;

// Ident complete when the last byte of a frame is taken
always @* begin
    ident_done = byte_take & asm_run_ff & (asm_ptr_ff == IDENT_BYTES - 1);
end

// Compare the assembled frame, with the final byte coming straight from the line
always @* begin
    asm_zero = (byte_s2_ff == 8'h00);
    asm_eq_last = (byte_s2_ff == last_ff[IDENT_BYTES-1]);
    asm_eq_cur = (byte_s2_ff == rx_ident_ff[IDENT_BYTES-1]);
    ident_mismatch = 1'b0;
    for (i = 0; i < IDENT_BYTES; i = i + 1) begin
        if (rx_ident_ff[i] != exp_ident_ff[i]) begin
            ident_mismatch = 1'b1;
        end
        if (i < IDENT_BYTES - 1) begin
            if (asm_ff[i] != 8'h00) begin
                asm_zero = 1'b0;
            end
            if (asm_ff[i] != last_ff[i]) begin
                asm_eq_last = 1'b0;
            end
            if (asm_ff[i] != rx_ident_ff[i]) begin
                asm_eq_cur = 1'b0;
            end
        end
    end
end

// ----------------------------------------------------------------
// Persistence counters and live status
// ----------------------------------------------------------------
reg [2:0] zero_cnt_ff;
reg [3:0] unstab_cnt_ff;
reg ident_idle_live_ff;
reg ident_unstable_live_ff;
reg ident_mismatch_live_ff;
reg ident_change_pulse_ff;
reg idle_prev_ff;
reg unstab_prev_ff;
reg mism_prev_ff;
wire asm_differs_cur;

assign asm_differs_cur = ~asm_eq_cur;

always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        zero_cnt_ff <= 3'h0;
        unstab_cnt_ff <= 4'h0;
        ident_idle_live_ff <= 1'b0;
        ident_unstable_live_ff <= 1'b0;
        ident_mismatch_live_ff <= 1'b0;
        ident_change_pulse_ff <= 1'b0;
        asm_ptr_ff <= {PTR_W{1'b0}};
        asm_run_ff <= 1'b0;
        for (n = 0; n < IDENT_BYTES; n = n + 1) begin
            rx_ident_ff[n] <= 8'h00;
            asm_ff[n] <= 8'h00;
            last_ff[n] <= 8'h00;
        end
    end else begin
        ident_change_pulse_ff <= 1'b0;
        // Taken from the stored identifier, so one errored frame cannot toggle the mismatch
        ident_mismatch_live_ff <= ident_mismatch;
        if (byte_take) begin
            if (start_s2_ff) begin
                asm_ff[0] <= byte_s2_ff;
                asm_ptr_ff <= {{(PTR_W-1){1'b0}}, 1'b1};
                asm_run_ff <= 1'b1;
            end else if (asm_run_ff) begin
                asm_ff[asm_ptr_ff] <= byte_s2_ff;
                asm_ptr_ff <= ptr_step(asm_ptr_ff);
                if (asm_ptr_ff == IDENT_BYTES - 1) begin
                    asm_run_ff <= 1'b0;
                end
            end
        end
        if (ident_done) begin
            for (n = 0; n < IDENT_BYTES - 1; n = n + 1) begin
                last_ff[n] <= asm_ff[n];
            end
            last_ff[IDENT_BYTES-1] <= byte_s2_ff;
            // Both counters saturate, so a long run cannot wrap and drop a declared status
            if (asm_zero) begin
                if (zero_cnt_ff != `TTRX_IDLE_COUNT) begin
                    zero_cnt_ff <= zero_cnt_ff + 3'h1;
                end
                if (zero_cnt_ff == `TTRX_IDLE_COUNT - 3'h1) begin
                    ident_idle_live_ff <= 1'b1;
                end
            end else begin
                zero_cnt_ff <= 3'h0;
                ident_idle_live_ff <= 1'b0;
            end
            // A frame that repeats the previous one is accepted as the new stored identifier
            if (asm_eq_last && asm_differs_cur) begin
                for (n = 0; n < IDENT_BYTES - 1; n = n + 1) begin
                    rx_ident_ff[n] <= asm_ff[n];
                end
                rx_ident_ff[IDENT_BYTES-1] <= byte_s2_ff;
                ident_change_pulse_ff <= 1'b1;
            end
            if (!asm_eq_last && asm_differs_cur) begin
                if (unstab_cnt_ff != `TTRX_UNSTABLE_COUNT) begin
                    unstab_cnt_ff <= unstab_cnt_ff + 4'h1;
                end
                if (unstab_cnt_ff == `TTRX_UNSTABLE_COUNT - 4'h1) begin
                    ident_unstable_live_ff <= 1'b1;
                end
            end else begin
                unstab_cnt_ff <= 4'h0;
                ident_unstable_live_ff <= 1'b0;
            end
        end
    end
end

// ----------------------------------------------------------------
// Register file
// ----------------------------------------------------------------
reg [3:0] latched_ff;
reg [3:0] irq_en_ff;
reg port_global_irq_en_ff;
reg [3:0] nxt_latched;
reg [3:0] rise_evt;
wire wr_latched;
wire wr_irq_en;
wire wr_ctrl;
wire wr_ptrs;
wire wr_exp;
wire rd_rx;
wire acc_exp;

// An unmapped offset matches none of these, so writes there are dropped
assign wr_latched = bus_hit(i_wr, i_addr, `TTRX_OFF_LATCHED);
assign wr_irq_en = bus_hit(i_wr, i_addr, `TTRX_OFF_IRQ_EN);
assign wr_ctrl = bus_hit(i_wr, i_addr, `TTRX_OFF_CTRL);
assign wr_ptrs = bus_hit(i_wr, i_addr, `TTRX_OFF_PTRS);
assign wr_exp = bus_hit(i_wr, i_addr, `TTRX_OFF_EXP_IDENT);
assign rd_rx = bus_hit(i_rd, i_addr, `TTRX_OFF_RX_IDENT);
assign acc_exp = bus_hit(i_rd | i_wr, i_addr, `TTRX_OFF_EXP_IDENT);

always @* begin
    rise_evt = 4'h0;
    rise_evt[`TTRX_BIT_CHANGE] = ident_change_pulse_ff;
    rise_evt[`TTRX_BIT_MISMATCH] = ident_mismatch_live_ff & ~mism_prev_ff;
    rise_evt[`TTRX_BIT_UNSTABLE] = ident_unstable_live_ff & ~unstab_prev_ff;
    rise_evt[`TTRX_BIT_IDLE] = ident_idle_live_ff & ~idle_prev_ff;
    nxt_latched = latched_ff;
    if (wr_latched) begin
        nxt_latched = latched_ff & ~i_wdata[3:0];
    end
    // A new event in the clearing cycle survives
    nxt_latched = nxt_latched | rise_evt;
end

always @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        latched_ff <= 4'h0;
        irq_en_ff <= `TTRX_IRQ_EN_RST;
        port_global_irq_en_ff <= 1'b0;
        idle_prev_ff <= 1'b0;
        unstab_prev_ff <= 1'b0;
        mism_prev_ff <= 1'b0;
        rx_ident_byte_ptr_ff <= {PTR_W{1'b0}};
        expected_ident_byte_ptr_ff <= {PTR_W{1'b0}};
        o_rdata <= 16'h0000;
        for (m = 0; m < IDENT_BYTES; m = m + 1) begin
            exp_ident_ff[m] <= 8'h00;
        end
    end else begin
        latched_ff <= nxt_latched;
        idle_prev_ff <= ident_idle_live_ff;
        unstab_prev_ff <= ident_unstable_live_ff;
        mism_prev_ff <= ident_mismatch_live_ff;
        if (wr_irq_en) begin
            irq_en_ff <= i_wdata[3:0];
        end
        if (wr_ctrl) begin
            port_global_irq_en_ff <= i_wdata[`TTRX_BIT_GLOBAL_EN];
        end
        if (wr_ptrs) begin
            rx_ident_byte_ptr_ff <= i_wdata[PTR_W-1:0];
            expected_ident_byte_ptr_ff <= i_wdata[`TTRX_EXP_PTR_LSB+PTR_W-1:`TTRX_EXP_PTR_LSB];
        end else begin
            // Pointer width matches the store depth, so natural overflow gives the Fh to 0h wrap
            if (rd_rx) begin
                rx_ident_byte_ptr_ff <= ptr_step(rx_ident_byte_ptr_ff);
            end
            if (acc_exp) begin
                expected_ident_byte_ptr_ff <= ptr_step(expected_ident_byte_ptr_ff);
            end
        end
        if (wr_exp) begin
            exp_ident_ff[expected_ident_byte_ptr_ff] <= i_wdata[7:0];
        end
        // Read data stands for one cycle only and is zero otherwise
        o_rdata <= 16'h0000;
        if (i_rd) begin
            case (i_addr)
                `TTRX_OFF_CTRL: o_rdata <= {15'h0000, port_global_irq_en_ff};
                `TTRX_OFF_PTRS: o_rdata <= {4'h0, expected_ident_byte_ptr_ff, 4'h0, rx_ident_byte_ptr_ff};
                `TTRX_OFF_LIVE_STATUS: o_rdata <= {13'h0000, ident_mismatch_live_ff,
                    ident_unstable_live_ff, ident_idle_live_ff};
                `TTRX_OFF_LATCHED: o_rdata <= {12'h000, latched_ff};
                `TTRX_OFF_IRQ_EN: o_rdata <= {12'h000, irq_en_ff};
                `TTRX_OFF_RX_IDENT: o_rdata <= {8'h00, rx_ident_ff[rx_ident_byte_ptr_ff]};
                `TTRX_OFF_EXP_IDENT: o_rdata <= {8'h00, exp_ident_ff[expected_ident_byte_ptr_ff]};
                default: o_rdata <= 16'h0000;
            endcase
        end
    end
end

// Level output: it drops once software clears the serviced latched bits, their irq enable bits or the global enable
assign o_irq = port_global_irq_en_ff & (|(latched_ff & irq_en_ff));

endmodule // ttrx_status

// *** ttrx_status_monitor.sv ***
// Checker of register reads and interrupt gating for the trail trace receive block
`timescale 1ns/1ps
module ttrx_status_monitor #(parameter IDENT_BYTES = 16, parameter PTR_W = 4) (
    input wire i_ref_clk,
    input wire i_rst_n,
    input wire [7:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [15:0] o_rdata,
    input wire [7:0] i_line_byte,
    input wire i_line_valid,
    input wire i_line_ident_start,
    input wire o_irq
);
    // --------
    // Shadow of settings seen on the bus
    // --------
    reg [3:0] ie_ff;
    reg glb_ff;
    reg [3:0] rp_ff;
    reg [3:0] ep_ff;
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ie_ff <= 4'h0;
            glb_ff <= 1'b0;
            rp_ff <= 4'h0;
            ep_ff <= 4'h0;
        end else begin
            if (i_wr && i_addr == 8'hF8) ie_ff <= i_wdata[3:0];
            if (i_wr && i_addr == 8'hF0) glb_ff <= i_wdata[0];
            if (i_wr && i_addr == 8'hF2) begin
                rp_ff <= i_wdata[3:0];
                ep_ff <= i_wdata[11:8];
            end
            // Four-bit adders wrap Fh to 0h by themselves
            if (i_rd && i_addr == 8'hFC) rp_ff <= rp_ff + 4'h1;
            if ((i_rd || i_wr) && i_addr == 8'hFE) ep_ff <= ep_ff + 4'h1;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    property p_rx_hi; i_rd && i_addr == 8'hFC |=> o_rdata[15:8] == 8'h00; endproperty
    a_rx_hi: assert property (p_rx_hi) else $error("rx byte upper half set");
    property p_exp_hi; i_rd && i_addr == 8'hFE ##1 1'b1 |-> o_rdata[15:8] == 8'h00; endproperty
    a_exp_hi: assert property (p_exp_hi) else $error("expected byte upper half set");
    property p_rx_ptr; i_rd && i_addr == 8'hF2 |=> o_rdata[3:0] == rp_ff; endproperty
    a_rx_ptr: assert property (p_rx_ptr) else $error("rx pointer wrong");
    property p_exp_ptr; i_rd && i_addr == 8'hF2 |=> o_rdata[11:8] == ep_ff; endproperty
    a_exp_ptr: assert property (p_exp_ptr) else $error("expected pointer wrong");
    property p_irq_gate; o_irq |-> glb_ff && ie_ff != 4'h0; endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");
    property p_ie_rb; i_rd && i_addr == 8'hF8 |=> o_rdata == {12'h000, ie_ff}; endproperty
    a_ie_rb: assert property (p_ie_rb) else $error("irq enable readback wrong");
    property p_lat_hi; $past(i_rd) && $past(i_addr) == 8'hF6 |-> o_rdata[15:4] == 12'h000; endproperty
    a_lat_hi: assert property (p_lat_hi) else $error("latched upper bits set");
    property p_live_hi; i_rd && i_addr == 8'hF4 |=> o_rdata[15:3] == 13'h0000; endproperty
    a_live_hi: assert property (p_live_hi) else $error("live upper bits set");
endmodule // ttrx_status_monitor
bind ttrx_status ttrx_status_monitor #(.IDENT_BYTES(IDENT_BYTES), .PTR_W(PTR_W)) u_mon (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_line_byte(i_line_byte), .i_line_valid(i_line_valid), .i_line_ident_start(i_line_ident_start), .o_irq(o_irq));
